// ---- sirq_defines.svh ----
// Register offsets, field positions, reset values and counts of the mode/interrupt block
`ifndef SIRQ_DEFINES_SVH
`define SIRQ_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets (pointer byte values)
// ----------------------------------------------------------------------------
`define SIRQ_OFF_DATA_MSB0  8'h00
`define SIRQ_OFF_DATA_MSB3  8'h06
`define SIRQ_OFF_STATUS     8'h18
`define SIRQ_OFF_ERRCFG     8'h19
`define SIRQ_OFF_CONFIG     8'h1a
`define SIRQ_OFF_MUXCFG     8'h1b
`define SIRQ_OFF_RESET      8'h1c

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SIRQ_RST_STATUS     16'h0000
`define SIRQ_RST_ERRCFG     16'h0000
`define SIRQ_RST_CONFIG     16'h2801
`define SIRQ_RST_MUXCFG     16'h020f

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SIRQ_BIT_SLEEP      13
`define SIRQ_BIT_IRQ_DIS    7
`define SIRQ_BIT_SOFT_RST   15
`define SIRQ_DEGLITCH_MSB   2
`define SIRQ_DEGLITCH_LSB   0

// ----------------------------------------------------------------------------
// Deglitch select codes
// ----------------------------------------------------------------------------
`define SIRQ_DGL_1M0        3'h1
`define SIRQ_DGL_3M3        3'h4
`define SIRQ_DGL_10M        3'h5
`define SIRQ_DGL_33M        3'h3

// ----------------------------------------------------------------------------
// Target addresses and timing
// ----------------------------------------------------------------------------
`define SIRQ_I2C_ADDR_LO    7'h2a
`define SIRQ_I2C_ADDR_HI    7'h2b
`define SIRQ_WAKE_CYCLES    16384

`endif

// ---- sirq_pkg.sv ----
// Types shared by the mode/interrupt block
package sirq_pkg;

  typedef enum logic [4:0] {
    SIRQ_IDLE = 5'b00001,
    SIRQ_ADDR = 5'b00010,
    SIRQ_PTR  = 5'b00100,
    SIRQ_WR   = 5'b01000,
    SIRQ_RD   = 5'b10000
  } sirq_i2c_st_t;

  typedef enum logic [3:0] {
    SIRQ_BAND_1M0 = 4'b0001,
    SIRQ_BAND_3M3 = 4'b0010,
    SIRQ_BAND_10M = 4'b0100,
    SIRQ_BAND_33M = 4'b1000
  } sirq_band_t;

  // Pin inputs bundled for the synchronisers
  typedef struct packed {
    logic scl;
    logic sda;
    logic shutdown_pin;
    logic addr_sel;
  } sirq_pins_t;

  // Whole state of the block
  typedef struct packed {
    sirq_pins_t    sync1;
    sirq_pins_t    sync2;
    logic          scl_q;
    logic          sda_q;
    logic          shdn_q;
    sirq_i2c_st_t  st;
    logic [3:0]    cnt;
    logic [7:0]    sh;
    logic [7:0]    ptr;
    logic          ackme;
    logic          hb;
    logic [7:0]    wr_hi;
    logic [15:0]   tx;
    logic          drv;
    logic [15:0]   status;
    logic [15:0]   errcfg;
    logic [15:0]   conv_cfg;
    logic [15:0]   muxcfg;
    logic [14:0]   wake_cnt;
    logic          run;
    logic          irq_n;
    logic          clr;
    sirq_band_t    band;
  } sirq_state_t;

endpackage

// ---- sirq_ctrl.sv ----
// Mode control, status/interrupt logic and I2C register target of the sensing converter
//
// Summary of operation
// - Interrupt asserts only for events whose mask bit is set and pin disable clear.
// - Status freezes once any bit sets, until status or result-upper read.
// - Sleep entry, reset, shutdown, soft reset or status read clear the interrupt.
// - Status read clears error bits and faulting channel field, releases interrupt.
// - Pin disable bit at one holds the interrupt pin high.
// - Three-bit field selects glitch band: 001 1M, 100 3.3M, 101 10M, 011 33M.
// - After power-up device sleeps, no conversions, until host clears sleep bit.
// - Sleep bit one enters sleep, zero leaves; configuration kept in sleep.
// - After leaving sleep wait 16384 internal clock cycles before first activation.
// - In sleep no conversions, but I2C register access keeps working.
// - Entering sleep clears results and error conditions, releases interrupt.
// - Shutdown pin high forces shutdown and default registers; low leaves it.
// - In shutdown no conversions, errors cleared, interrupt released, I2C ignored.
// - Soft reset bit stops conversion, restores defaults, always reads zero.
// - I2C up to 400 kbit/s: 7-bit address then 8-bit register pointer.
// - Target address 0x2A with select pin low, 0x2B with it high.
// - In conversion mode each active channel is measured periodically.
`timescale 1ns/1ps
`include "sirq_defines.svh"

module sirq_ctrl #(
  parameter int WAKE_CYCLES = `SIRQ_WAKE_CYCLES
) (
  input  wire logic               clk_sys_i,
  input  wire logic               rst_i,
  input  wire logic               scl_i,
  input  wire logic               sda_i,
  output wire logic               sda_o,
  output wire logic               sda_oen_o,
  input  wire logic               shutdown_pin_i,
  input  wire logic               addr_sel_i,
  input  wire logic [15:0]        status_evt_i,
  output wire logic               interrupt_out_n_o,
  output wire logic               conv_run_o,
  output wire logic               clear_results_o,
  output wire logic [15:0]        config_o,
  output wire logic [15:0]        channel_select_cfg_o,
  output sirq_pkg::sirq_band_t    glitch_band_o
);
  import sirq_pkg::*;

  sirq_state_t s_r;
  sirq_state_t s_nxt;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    logic        scl;
    logic        sda;
    logic        rise;
    logic        fall;
    logic        start;
    logic        stop;
    logic [7:0]  byte_in;
    logic [6:0]  my_addr;
    logic        rd_load;
    logic        rd_clr;
    logic        sleep_was;
    logic        soft_rst;
    logic [15:0] rdata;
    scl       = s_r.sync2.scl;
    sda       = s_r.sync2.sda;
    rise      = scl & ~s_r.scl_q;
    fall      = ~scl & s_r.scl_q;
    start     = scl & s_r.scl_q & s_r.sda_q & ~sda;
    stop      = scl & s_r.scl_q & ~s_r.sda_q & sda;
    byte_in   = {s_r.sh[6:0], sda};
    my_addr   = s_r.sync2.addr_sel ? `SIRQ_I2C_ADDR_HI : `SIRQ_I2C_ADDR_LO;
    rd_load   = 1'b0;
    rd_clr    = 1'b0;
    soft_rst  = 1'b0;
    sleep_was = s_r.conv_cfg[`SIRQ_BIT_SLEEP];
    rdata     = 16'h0000;

    s_nxt       = s_r;
    s_nxt.sync1 = {scl_i, sda_i, shutdown_pin_i, addr_sel_i};
    s_nxt.sync2 = s_r.sync1;
    s_nxt.scl_q = scl;
    s_nxt.sda_q = sda;
    s_nxt.shdn_q = s_r.sync2.shutdown_pin;
    s_nxt.clr   = 1'b0;

    // ------------------------------------------------------------------------
    // I2C target: address, pointer byte, then 16-bit words high byte first
    // ------------------------------------------------------------------------
    if (start)
    begin
      s_nxt.st    = SIRQ_ADDR;
      s_nxt.cnt   = 4'h0;
      s_nxt.drv   = 1'b0;
      s_nxt.ackme = 1'b0;
    end
    else if (stop)
    begin
      s_nxt.st  = SIRQ_IDLE;
      s_nxt.drv = 1'b0;
    end
    else if (rise && s_r.st != SIRQ_IDLE)
    begin
      if (s_r.cnt != 4'h8)
      begin
        s_nxt.sh  = byte_in;
        s_nxt.cnt = s_r.cnt + 4'h1;
        if (s_r.st == SIRQ_RD)
          s_nxt.tx = {s_r.tx[14:0], 1'b0};
        if (s_r.cnt == 4'h7)
        begin
          case (s_r.st)
            SIRQ_ADDR: s_nxt.ackme = (byte_in[7:1] == my_addr);
            SIRQ_PTR:
            begin
              s_nxt.ptr   = byte_in;
              s_nxt.ackme = 1'b1;
            end
            SIRQ_WR:
            begin
              s_nxt.ackme = 1'b1;
              if (s_r.hb)
              begin
                s_nxt.wr_hi = byte_in;
                s_nxt.hb    = 1'b0;
              end
              else
              begin
                s_nxt.hb  = 1'b1;
                s_nxt.ptr = s_r.ptr + 8'h01;
                case (s_r.ptr)
                  `SIRQ_OFF_ERRCFG: s_nxt.errcfg = {s_r.wr_hi, byte_in};
                  `SIRQ_OFF_CONFIG: s_nxt.conv_cfg = {s_r.wr_hi, byte_in};
                  `SIRQ_OFF_MUXCFG: s_nxt.muxcfg = {s_r.wr_hi, byte_in};
                  `SIRQ_OFF_RESET:  soft_rst = s_r.wr_hi[`SIRQ_BIT_SOFT_RST - 8];
                  default:          s_nxt.ptr = s_r.ptr + 8'h01;
                endcase
              end
            end
            default: s_nxt.ackme = 1'b0;
          endcase
        end
      end
      else
      begin
        // Ninth clock: our acknowledge, or the host's one while reading
        s_nxt.cnt = 4'h0;
        case (s_r.st)
          SIRQ_ADDR:
          begin
            if (!s_r.ackme)
              s_nxt.st = SIRQ_IDLE;
            else if (s_r.sh[0])
            begin
              s_nxt.st = SIRQ_RD;
              s_nxt.hb = 1'b1;
              rd_load  = 1'b1;
            end
            else
              s_nxt.st = SIRQ_PTR;
          end
          SIRQ_PTR:
          begin
            s_nxt.st = SIRQ_WR;
            s_nxt.hb = 1'b1;
          end
          SIRQ_RD:
          begin
            s_nxt.hb = ~s_r.hb;
            if (sda)
              s_nxt.st = SIRQ_IDLE;
            else if (!s_r.hb)
              rd_load = 1'b1;
          end
          default: s_nxt.st = s_r.st;
        endcase
      end
    end
    else if (fall)
    begin
      if (s_r.st == SIRQ_RD)
        s_nxt.drv = (s_r.cnt != 4'h8) & ~s_r.tx[15];
      else
        s_nxt.drv = (s_r.cnt == 4'h8) & s_r.ackme & (s_r.st != SIRQ_IDLE);
    end

    // ------------------------------------------------------------------------
    // Read data and read side effects
    // ------------------------------------------------------------------------
    case (s_r.ptr)
      `SIRQ_OFF_STATUS: rdata = s_r.status;
      `SIRQ_OFF_ERRCFG: rdata = s_r.errcfg;
      `SIRQ_OFF_CONFIG: rdata = s_r.conv_cfg;
      `SIRQ_OFF_MUXCFG: rdata = s_r.muxcfg;
      default:          rdata = 16'h0000;
    endcase
    if (rd_load)
    begin
      s_nxt.tx  = rdata;
      s_nxt.ptr = s_r.ptr + 8'h01;
      // Result-upper reads carry the error flags, so they also unfreeze status
      rd_clr    = (s_r.ptr == `SIRQ_OFF_STATUS) ||
                  (!s_r.ptr[0] && s_r.ptr <= `SIRQ_OFF_DATA_MSB3);
    end

    // ------------------------------------------------------------------------
    // Sleep, soft reset and status capture
    // ------------------------------------------------------------------------
    if (soft_rst)
    begin
      s_nxt.errcfg   = `SIRQ_RST_ERRCFG;
      s_nxt.conv_cfg = `SIRQ_RST_CONFIG;
      s_nxt.muxcfg   = `SIRQ_RST_MUXCFG;
      s_nxt.clr    = 1'b1;
    end
    if (s_nxt.conv_cfg[`SIRQ_BIT_SLEEP] && !sleep_was)
      s_nxt.clr = 1'b1;

    // A new event in a read-clear cycle is kept; sleep entry or soft reset clears it
    if (rd_clr || s_nxt.clr || s_r.status == 16'h0000)
      s_nxt.status = s_nxt.clr ? 16'h0000 : status_evt_i;

    if (s_nxt.conv_cfg[`SIRQ_BIT_SLEEP] || soft_rst)
    begin
      s_nxt.run      = 1'b0;
      s_nxt.wake_cnt = 15'h0000;
    end
    else if (!s_r.run)
    begin
      if (32'(s_r.wake_cnt) >= WAKE_CYCLES - 1)
        s_nxt.run = 1'b1;
      else
        s_nxt.wake_cnt = s_r.wake_cnt + 15'h0001;
    end

    // ------------------------------------------------------------------------
    // Shutdown overrides I2C state, registers, status, wake and run; pointer and synchronisers keep going
    // ------------------------------------------------------------------------
    if (s_r.sync2.shutdown_pin)
    begin
      s_nxt.st       = SIRQ_IDLE;
      s_nxt.drv      = 1'b0;
      s_nxt.cnt      = 4'h0;
      s_nxt.status   = `SIRQ_RST_STATUS;
      s_nxt.errcfg   = `SIRQ_RST_ERRCFG;
      s_nxt.conv_cfg = `SIRQ_RST_CONFIG;
      s_nxt.muxcfg   = `SIRQ_RST_MUXCFG;
      s_nxt.run      = 1'b0;
      s_nxt.wake_cnt = 15'h0000;
      s_nxt.clr      = ~s_r.shdn_q;
    end

    // Undefined codes fall back to the widest band so no signal is lost
    case (s_nxt.muxcfg[`SIRQ_DEGLITCH_MSB:`SIRQ_DEGLITCH_LSB])
      `SIRQ_DGL_1M0: s_nxt.band = SIRQ_BAND_1M0;
      `SIRQ_DGL_3M3: s_nxt.band = SIRQ_BAND_3M3;
      `SIRQ_DGL_10M: s_nxt.band = SIRQ_BAND_10M;
      `SIRQ_DGL_33M: s_nxt.band = SIRQ_BAND_33M;
      default:       s_nxt.band = SIRQ_BAND_33M;
    endcase

    // Active low, driven only by unmasked events with the pin enabled
    s_nxt.irq_n = ~((|(s_nxt.status & s_nxt.errcfg)) &
                    ~s_nxt.conv_cfg[`SIRQ_BIT_IRQ_DIS]);
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_r          <= '0;
      s_r.st       <= SIRQ_IDLE;
      s_r.status   <= `SIRQ_RST_STATUS;
      s_r.errcfg   <= `SIRQ_RST_ERRCFG;
      s_r.conv_cfg <= `SIRQ_RST_CONFIG;
      s_r.muxcfg   <= `SIRQ_RST_MUXCFG;
      s_r.irq_n    <= 1'b1;
      s_r.sync1    <= 4'hc;
      s_r.sync2    <= 4'hc;
      s_r.scl_q    <= 1'b1;
      s_r.sda_q    <= 1'b1;
      s_r.band     <= SIRQ_BAND_33M;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign sda_o                = 1'b0;
  assign sda_oen_o            = ~s_r.drv;
  assign interrupt_out_n_o    = s_r.irq_n;
  assign conv_run_o           = s_r.run;
  assign clear_results_o      = s_r.clr;
  assign config_o             = s_r.conv_cfg;
  assign channel_select_cfg_o = s_r.muxcfg;
  assign glitch_band_o        = s_r.band;

endmodule // sirq_ctrl

// ---- sirq_ctrl_properties.sv ----
// Port-level assertions for the mode, status and interrupt block
`timescale 1ns/1ps
module sirq_ctrl_properties #(
  parameter int WAKE_CYCLES = 16384
) (
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oen_o,
  input wire logic        shutdown_pin_i,
  input wire logic        addr_sel_i,
  input wire logic [15:0] status_evt_i,
  input wire logic        interrupt_out_n_o,
  input wire logic        conv_run_o,
  input wire logic        clear_results_o,
  input wire logic [15:0] config_o,
  input wire logic [15:0] channel_select_cfg_o,
  input sirq_pkg::sirq_band_t glitch_band_o
);
  import sirq_pkg::*;
  logic [15:0] awake_r;
  sirq_band_t  band_exp;
  // Awake cycles since the sleep bit cleared; saturates so it never wraps
  always_ff @(posedge clk_sys_i or posedge rst_i)
    if (rst_i)
      awake_r <= 16'h0000;
    else
      awake_r <= config_o[13] ? 16'h0000 : awake_r + {15'h0000, ~&awake_r};
  always_comb
    case (channel_select_cfg_o[2:0])
      3'h1:    band_exp = SIRQ_BAND_1M0;
      3'h4:    band_exp = SIRQ_BAND_3M3;
      3'h5:    band_exp = SIRQ_BAND_10M;
      default: band_exp = SIRQ_BAND_33M;
    endcase
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  AST_IRQ_DIS: assert property (
    config_o[7] && $past(config_o[7]) |-> interrupt_out_n_o) else $error("irq while disabled");
  AST_SLEEP_CLR: assert property (
    $rose(config_o[13]) |-> ##[0:2] clear_results_o) else $error("no clear on sleep");
  AST_SLEEP_IRQ: assert property (
    $rose(config_o[13]) |-> ##[1:2] interrupt_out_n_o) else $error("irq kept in sleep");
  AST_SLEEP_RUN: assert property (
    config_o[13] |=> !conv_run_o) else $error("running in sleep");
  AST_WAKE: assert property (
    $rose(conv_run_o) |-> awake_r >= WAKE_CYCLES - 2 && awake_r <= WAKE_CYCLES + 2)
    else $error("wake delay off");
  AST_SHDN_REGS: assert property (
    shutdown_pin_i [*4] |=> config_o == 16'h2801 && channel_select_cfg_o == 16'h020f)
    else $error("no defaults in shutdown");
  AST_SHDN_CLR: assert property (
    $rose(shutdown_pin_i) |-> ##[2:4] clear_results_o) else $error("no clear on shutdown");
  AST_SHDN_QUIET: assert property (
    shutdown_pin_i [*4] |=> sda_oen_o && interrupt_out_n_o && !conv_run_o)
    else $error("active in shutdown");
  AST_BAND: assert property (
    $stable(channel_select_cfg_o) |-> glitch_band_o == band_exp) else $error("band wrong");
endmodule // sirq_ctrl_properties
bind sirq_ctrl sirq_ctrl_properties #(.WAKE_CYCLES(WAKE_CYCLES)) u_sirq_ctrl_properties (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oen_o(sda_oen_o), .shutdown_pin_i(shutdown_pin_i), .addr_sel_i(addr_sel_i),
  .status_evt_i(status_evt_i), .interrupt_out_n_o(interrupt_out_n_o),
  .conv_run_o(conv_run_o), .clear_results_o(clear_results_o), .config_o(config_o),
  .channel_select_cfg_o(channel_select_cfg_o), .glitch_band_o(glitch_band_o));

// ---- sirq_i2c_host.sv ----
// Bit-level serial host model for the register port
`timescale 1ns/1ps
module sirq_i2c_host (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o = 1'b1,
  output logic      sda_o = 1'b1
);
  // One quarter of the 800 ns bit; both lines move just after an edge
  task automatic mv(input logic c, input logic s);
    repeat (2) @(posedge clk_i);
    scl_o <= c;
    sda_o <= s;
  endtask
  // Data moves only while the clock is low and is sampled in the middle of the high phase
  task automatic bt(input logic b, output logic r);
    mv(1'b0, b);
    mv(1'b1, b);
    repeat (2) @(posedge clk_i);
    r = sda_i;
    mv(1'b0, b);
  endtask
  task automatic wb(input logic [7:0] b, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--)
      bt(b[i], r);
    bt(1'b1, r);
    ok = ok & ~r;
  endtask
  task automatic sta;
    mv(1'b0, 1'b1);
    mv(1'b1, 1'b1);
    mv(1'b1, 1'b0);
    mv(1'b0, 1'b0);
  endtask
  // Address byte, pointer byte, then one word high byte first
  task automatic acc(input logic rd, input logic [6:0] a, input logic [7:0] p,
                     inout logic [15:0] d, output logic ok);
    logic r;
    ok = 1'b1;
    sta;
    wb({a, 1'b0}, ok);
    wb(p, ok);
    if (!rd)
    begin
      wb(d[15:8], ok);
      wb(d[7:0], ok);
    end
    else
    begin
      sta;
      wb({a, 1'b1}, ok);
      for (int i = 15; i >= 0; i--)
      begin
        bt(1'b1, d[i]);
        if (i == 8)
          bt(1'b0, r);
      end
      bt(1'b1, r);
    end
    mv(1'b0, 1'b0);
    mv(1'b1, 1'b0);
    mv(1'b1, 1'b1);
  endtask
endmodule // sirq_i2c_host

// ---- sirq_ctrl_tb.sv ----
// Self-checking bench of the mode, status and interrupt block
`timescale 1ns/1ps
module sirq_ctrl_tb;
  import sirq_pkg::*;
  localparam int W = 64;  // Short wake count keeps the run brief
  logic clk_sys_i, rst_i, shdn, asel, scl, hsda, sdev, oen, irq_n, run, clr, sda;
  logic [15:0] evt, cfg, mux;
  logic [6:0]  ad;
  sirq_band_t  band;
  int          fails = 0;
  int          checks_done = 0;
  assign sda = hsda & (oen | sdev);
  sirq_ctrl #(.WAKE_CYCLES(W)) u_sirq_ctrl (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sdev), .sda_oen_o(oen), .shutdown_pin_i(shdn),
    .addr_sel_i(asel), .status_evt_i(evt), .interrupt_out_n_o(irq_n), .conv_run_o(run),
    .clear_results_o(clr), .config_o(cfg), .channel_select_cfg_o(mux), .glitch_band_o(band));
  sirq_i2c_host u_sirq_i2c_host (.clk_i(clk_sys_i), .sda_i(sda), .scl_o(scl), .sda_o(hsda));
  initial
  begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  // One word access; for a read d is the expected value
  task automatic rw(input logic rd, input logic [7:0] p, input logic [15:0] d, input logic ak);
    logic [15:0] v;
    logic        ok;
    v = d;
    u_sirq_i2c_host.acc(rd, ad, p, v, ok);
    chk(ok, ak);
    if (rd && ak)
      chk(v, d);
  endtask
  task automatic ev(input logic [15:0] e);
    evt <= e;
    @(posedge clk_sys_i);
    evt <= 16'h0000;
    repeat (4) @(posedge clk_sys_i);
  endtask
  task automatic t_reset;
    chk(cfg, 16'h2801);
    chk(run, 16'h0);
    chk(irq_n, 16'h1);
    rw(1'b1, 8'h18, 16'h0000, 1'b1);
    rw(1'b1, 8'h30, 16'h0000, 1'b1);
  endtask
  task automatic t_wake;
    rw(1'b0, 8'h1a, 16'h0000, 1'b1);
    chk(run, 16'h0);
    repeat (W + 8) @(posedge clk_sys_i);
    chk(run, 16'h1);
  endtask
  task automatic t_irq;
    ev(16'h0008);
    chk(irq_n, 16'h1);
    rw(1'b1, 8'h18, 16'h0008, 1'b1);
    rw(1'b1, 8'h18, 16'h0000, 1'b1);
    rw(1'b0, 8'h19, 16'h0008, 1'b1);
    ev(16'h0008);
    chk(irq_n, 16'h0);
    ev(16'h0010);
    rw(1'b1, 8'h18, 16'h0008, 1'b1);
    chk(irq_n, 16'h1);
    rw(1'b0, 8'h1a, 16'h0080, 1'b1);
    ev(16'h0008);
    chk(irq_n, 16'h1);
    rw(1'b0, 8'h1a, 16'h0000, 1'b1);
    chk(irq_n, 16'h0);
    // A result-upper read unfreezes status and releases the pin as well
    rw(1'b1, 8'h02, 16'h0000, 1'b1);
    chk(irq_n, 16'h1);
    rw(1'b1, 8'h18, 16'h0000, 1'b1);
    ev(16'h0008);
    chk(irq_n, 16'h0);
    rw(1'b0, 8'h1a, 16'h2000, 1'b1);
    chk(irq_n, 16'h1);
    chk(run, 16'h0);
    rw(1'b1, 8'h18, 16'h0000, 1'b1);
  endtask
  task automatic bnd(input logic [2:0] c, input sirq_band_t b);
    rw(1'b0, 8'h1b, {13'h0041, c}, 1'b1);
    chk(band, b);
    rw(1'b1, 8'h1b, {13'h0041, c}, 1'b1);
  endtask
  task automatic t_band;
    bnd(3'h1, SIRQ_BAND_1M0);
    bnd(3'h4, SIRQ_BAND_3M3);
    bnd(3'h5, SIRQ_BAND_10M);
    bnd(3'h3, SIRQ_BAND_33M);
    // Settle on the lowest band above the sensor's top frequency
    bnd(3'h4, SIRQ_BAND_3M3);
    chk(cfg, 16'h2000);
  endtask
  task automatic t_soft;
    rw(1'b0, 8'h1c, 16'h8000, 1'b1);
    chk(mux, 16'h020f);
    chk(cfg, 16'h2801);
    rw(1'b1, 8'h1c, 16'h0000, 1'b1);
  endtask
  // Select pin moves in the same step as the shutdown pin is released
  task automatic t_shut;
    rw(1'b0, 8'h19, 16'h00ff, 1'b1);
    shdn <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    rw(1'b0, 8'h19, 16'h0001, 1'b0);
    asel <= 1'b1;
    shdn <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    rw(1'b1, 8'h19, 16'h0000, 1'b0);
    ad = 7'h2b;
    rw(1'b1, 8'h19, 16'h0000, 1'b1);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #4000000;
    fails++;
    report_and_stop;
  end
  initial
  begin
    rst_i = 1'b1;
    shdn = 1'b0;
    asel = 1'b0;
    evt = 16'h0000;
    ad = 7'h2a;
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    t_reset;
    t_wake;
    t_irq;
    t_band;
    t_soft;
    t_shut;
    report_and_stop;
  end
endmodule // sirq_ctrl_tb
